/* File: verilog/aite_regs.svh */
`ifndef AITE_REGS_SVH
`define AITE_REGS_SVH
// register byte offsets
`define AITE_CTRL 12'h000
`define AITE_TRIG 12'h004
`define AITE_SCLK 12'h008
`define AITE_CCLK 12'h00C
`define AITE_PRE 12'h010
`define AITE_POST 12'h014
`define AITE_SDIV 12'h018
`define AITE_CDIV 12'h01C
`define AITE_SDLY 12'h020
`define AITE_CDLY 12'h024
`define AITE_NCH 12'h028
`define AITE_STAT 12'h02C
`define AITE_CNT 12'h030
// reset values
`define AITE_SDLY_RST 16'h0002
`define AITE_CDLY_RST 16'h0003
`define AITE_NCH_RST 8'h01
// ctrl fields
`define AITE_C_ARM 0
`define AITE_C_SWSTART 1
`define AITE_C_SWSAMP 2
`define AITE_C_STOP 3
`define AITE_C_PRETRIG 4
`define AITE_C_FINITE 5
`define AITE_C_OUTLVL 6
// trig fields
`define AITE_T_STSW 0
`define AITE_T_STEDGE 1
`define AITE_T_STSEL 7:4
`define AITE_T_RFEDGE 8
`define AITE_T_RFSEL 15:12
`define AITE_T_PSEN 16
`define AITE_T_PSLVL 17
`define AITE_T_PSSEL 23:20
`define AITE_T_OUTSEL 27:24
// sample clock fields
`define AITE_S_SRC 1:0
`define AITE_S_EDGE 2
`define AITE_S_TBSRC 5:4
`define AITE_S_TBEDGE 6
`define AITE_S_LINE 11:8
`define AITE_S_TBLINE 15:12
// convert clock fields
`define AITE_V_EXT 0
`define AITE_V_EDGE 1
`define AITE_V_TBSRC 2
`define AITE_V_LINE 7:4
// timebase rates in hz
`define AITE_TB_FAST_HZ 20000000
`define AITE_TB_SLOW_HZ 100000
`endif

/* File: verilog/aite_pkg.sv */
package aite_pkg;
  typedef enum logic [2:0] {
    AITE_IDLE = 3'b000,
    AITE_WAIT = 3'b001,
    AITE_PRE = 3'b011,
    AITE_ARMREF = 3'b010,
    AITE_POST = 3'b110,
    AITE_DONE = 3'b111
  } aite_state_t;
  typedef enum logic [1:0] {
    AITE_SS_CTR = 2'h0,
    AITE_SS_DIV = 2'h1,
    AITE_SS_SW = 2'h2,
    AITE_SS_PIN = 2'h3
  } aite_ssrc_t;
  typedef enum logic [1:0] {
    AITE_TB_FAST = 2'h0,
    AITE_TB_SLOW = 2'h1,
    AITE_TB_PIN = 2'h2
  } aite_tbsrc_t;
endpackage : aite_pkg

/* File: verilog/aite_engine.sv */
`timescale 1ns/1ps
`include "aite_regs.svh"
module aite_engine #(
  parameter int NLINES = 16,
  parameter int CW = 24,
  parameter int SYS_HZ = 25000000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // programmable lines and counter output
  input wire logic [NLINES-1:0] programmable_io_line_in,
  output logic [NLINES-1:0] programmable_io_line_out,
  output logic [NLINES-1:0] programmable_io_line_oe,
  input wire logic counter_internal_out,
  // converter
  output logic adc_convert_strobe,
  output logic [7:0] adc_channel_index,
  output logic acq_active
);
  localparam int LW = $clog2(NLINES);
  localparam logic [CW-1:0] FAST_DIV = CW'(SYS_HZ / `AITE_TB_FAST_HZ);
  localparam logic [CW-1:0] SLOW_DIV = CW'(SYS_HZ / `AITE_TB_SLOW_HZ);

  // elaboration-time refusal of settings the logic cannot serve
  if (NLINES < 2 || NLINES > 16 || CW < 16 || CW > 32 ||
      SYS_HZ < `AITE_TB_FAST_HZ) begin : g_bad_cfg
    $error("aite_engine: unsupported NLINES, CW or SYS_HZ");
  end

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic [31:0] ctrl;
    logic [31:0] trig;
    logic [31:0] sclk;
    logic [31:0] cclk;
    logic [CW-1:0] pre;
    logic [CW-1:0] post;
    logic [CW-1:0] sdiv;
    logic [CW-1:0] cdiv;
    logic [15:0] sdly;
    logic [15:0] cdly;
    logic [7:0] nch;
    logic [NLINES-1:0] sync1;
    logic [NLINES-1:0] sync2;
    logic [NLINES-1:0] prev;
    logic cnt_prev;
    logic [CW-1:0] fast_cnt;
    logic [CW-1:0] slow_cnt;
    aite_pkg::aite_state_t st;
    logic [CW-1:0] samples;
    logic [CW-1:0] stb_cnt;
    logic [15:0] sdly_cnt;
    logic in_sample;
    logic [7:0] conv_left;
    logic [CW-1:0] conv_cnt;
    logic [15:0] cdly_cnt;
    logic conv_first;
    logic conv;
    logic [7:0] chan;
    logic samp_pulse;
    logic start_pulse;
    logic done;
  } aite_state_struct_t;

  aite_state_struct_t q;
  aite_state_struct_t d;

  // line edge helpers, synchronised copies only
  logic [NLINES-1:0] rise;
  logic [NLINES-1:0] fall;
  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi++) begin : g_edge
      assign rise[gi] = q.sync2[gi] & ~q.prev[gi];
      assign fall[gi] = ~q.sync2[gi] & q.prev[gi];
    end
  endgenerate

  logic tick_fast;
  logic tick_slow;
  logic tb_tick;
  logic hold_gate;
  logic start_hw;
  logic start_ev;
  logic ref_ev;
  logic samp_raw;
  logic samp_acc;
  logic conv_raw;
  logic conv_acc;
  logic run;
  logic wr_fire;
  logic rd_ok;
  logic [31:0] rd_val;

  function automatic logic edge_of(input logic [NLINES-1:0] r, input logic [NLINES-1:0] f,
                                   input logic [3:0] sel, input logic fall_sel);
    logic [LW-1:0] ix;
    ix = sel[LW-1:0];
    edge_of = fall_sel ? f[ix] : r[ix];
  endfunction : edge_of

  always_comb begin
    d = q;
    d.sync1 = programmable_io_line_in;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    d.cnt_prev = counter_internal_out;
    d.start_pulse = 1'b0;
    d.conv = 1'b0;
    d.samp_pulse = 1'b0;
    tick_fast = (q.fast_cnt == '0);
    tick_slow = (q.slow_cnt == '0);
    d.fast_cnt = tick_fast ? (FAST_DIV - CW'(1)) : (q.fast_cnt - CW'(1));
    d.slow_cnt = tick_slow ? (SLOW_DIV - CW'(1)) : (q.slow_cnt - CW'(1));
    case (aite_pkg::aite_tbsrc_t'(q.sclk[`AITE_S_TBSRC]))
      aite_pkg::AITE_TB_FAST: tb_tick = tick_fast;
      aite_pkg::AITE_TB_SLOW: tb_tick = tick_slow;
      aite_pkg::AITE_TB_PIN: tb_tick = edge_of(rise, fall, q.sclk[`AITE_S_TBLINE],
                                                q.sclk[`AITE_S_TBEDGE]);
      default: tb_tick = tick_fast;
    endcase
    hold_gate = q.trig[`AITE_T_PSEN] &
                (q.sync2[q.trig[`AITE_T_PSSEL] & 4'(NLINES - 1)] == q.trig[`AITE_T_PSLVL]);
    start_hw = edge_of(rise, fall, q.trig[`AITE_T_STSEL], q.trig[`AITE_T_STEDGE]);
    ref_ev = edge_of(rise, fall, q.trig[`AITE_T_RFSEL], q.trig[`AITE_T_RFEDGE]);
    start_ev = 1'b0;
    run = (q.st == aite_pkg::AITE_PRE) || (q.st == aite_pkg::AITE_ARMREF) ||
          (q.st == aite_pkg::AITE_POST);
    if (q.st == aite_pkg::AITE_WAIT || q.st == aite_pkg::AITE_IDLE ||
        q.st == aite_pkg::AITE_DONE) begin
      d.stb_cnt = q.sdiv;
    end else if (tb_tick && q.sdly_cnt == '0 && !hold_gate) begin
      d.stb_cnt = (q.stb_cnt == '0) ? q.sdiv : q.stb_cnt - CW'(1);
    end
    if (run && tb_tick && q.sdly_cnt != '0)
      d.sdly_cnt = q.sdly_cnt - 16'(1);
    case (aite_pkg::aite_ssrc_t'(q.sclk[`AITE_S_SRC]))
      aite_pkg::AITE_SS_CTR: samp_raw = counter_internal_out & ~q.cnt_prev;
      aite_pkg::AITE_SS_DIV: samp_raw = tb_tick && q.sdly_cnt == '0 && q.stb_cnt == '0;
      aite_pkg::AITE_SS_SW: samp_raw = q.ctrl[`AITE_C_SWSAMP];
      aite_pkg::AITE_SS_PIN: samp_raw = edge_of(rise, fall, q.sclk[`AITE_S_LINE],
                                                 q.sclk[`AITE_S_EDGE]);
      default: samp_raw = 1'b0;
    endcase
    samp_acc = samp_raw && run && !hold_gate && !q.in_sample;
    if (q.cclk[`AITE_V_EXT])
      conv_raw = edge_of(rise, fall, q.cclk[`AITE_V_LINE], q.cclk[`AITE_V_EDGE]);
    else
      conv_raw = (q.cdly_cnt == '0) && (q.conv_cnt == '0) &&
                 (q.cclk[`AITE_V_TBSRC] ? tb_tick : tick_fast);
    conv_acc = conv_raw && q.in_sample;
    if (q.in_sample && (q.cclk[`AITE_V_TBSRC] ? tb_tick : tick_fast)) begin
      if (q.cdly_cnt != '0)
        d.cdly_cnt = q.cdly_cnt - 16'(1);
      else
        d.conv_cnt = (q.conv_cnt == '0) ? q.cdiv : q.conv_cnt - CW'(1);
    end
    if (samp_acc) begin
      d.in_sample = 1'b1;
      d.conv_left = q.nch;
      d.chan = '0;
      d.cdly_cnt = q.cdly;
      d.conv_cnt = '0;
      d.samp_pulse = 1'b1;
    end else if (conv_acc) begin
      d.conv = 1'b1;
      d.chan = q.chan + 8'(1);
      d.conv_left = q.conv_left - 8'(1);
      if (q.conv_left == 8'(1)) begin
        d.in_sample = 1'b0;
      end
    end
    // sequencer
    case (q.st)
      aite_pkg::AITE_IDLE: if (q.ctrl[`AITE_C_ARM]) d.st = aite_pkg::AITE_WAIT;
      aite_pkg::AITE_WAIT: begin
        start_ev = q.trig[`AITE_T_STSW] ? q.ctrl[`AITE_C_SWSTART] : start_hw;
        if (start_ev) begin
          d.start_pulse = q.trig[`AITE_T_STSW];
          d.sdly_cnt = q.sdly;
          if (q.ctrl[`AITE_C_PRETRIG]) begin
            d.samples = q.pre;
            d.st = aite_pkg::AITE_PRE;
          end else begin
            d.samples = q.post;
            d.st = aite_pkg::AITE_POST;
          end
        end
      end
      aite_pkg::AITE_PRE: if (samp_acc) begin
        d.samples = q.samples - CW'(1);
        if (q.samples == CW'(1)) d.st = aite_pkg::AITE_ARMREF;
      end
      aite_pkg::AITE_ARMREF: if (ref_ev) begin
        d.samples = q.post;
        d.st = aite_pkg::AITE_POST;
      end
      aite_pkg::AITE_POST: if (samp_acc && q.ctrl[`AITE_C_FINITE]) begin
        d.samples = q.samples - CW'(1);
        if (q.samples == CW'(1)) begin
          d.st = aite_pkg::AITE_DONE;
          d.done = 1'b1;
        end
      end
      aite_pkg::AITE_DONE: if (!q.ctrl[`AITE_C_ARM]) d.st = aite_pkg::AITE_IDLE;
      default: d.st = aite_pkg::AITE_IDLE;
    endcase
    if (q.ctrl[`AITE_C_STOP] && q.st != aite_pkg::AITE_IDLE) begin
      d.st = aite_pkg::AITE_DONE;
      d.in_sample = 1'b0;
    end
    // self-clearing command bits
    d.ctrl[`AITE_C_SWSTART] = 1'b0;
    d.ctrl[`AITE_C_SWSAMP] = 1'b0;
    d.ctrl[`AITE_C_STOP] = 1'b0;
    if (q.st == aite_pkg::AITE_WAIT) d.done = 1'b0;
    // axi4-lite write
    if (s_axi_awvalid && !q.aw_got) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
    end
    wr_fire = q.aw_got && q.w_got && !q.bvalid;
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'b00;
      case (q.awaddr)
        `AITE_CTRL: d.ctrl = q.wdata;
        `AITE_TRIG: d.trig = q.wdata;
        `AITE_SCLK: d.sclk = q.wdata;
        `AITE_CCLK: d.cclk = q.wdata;
        `AITE_PRE: d.pre = q.wdata[CW-1:0];
        `AITE_POST: d.post = q.wdata[CW-1:0];
        `AITE_SDIV: d.sdiv = q.wdata[CW-1:0];
        `AITE_CDIV: d.cdiv = q.wdata[CW-1:0];
        `AITE_SDLY: d.sdly = q.wdata[15:0];
        `AITE_CDLY: d.cdly = q.wdata[15:0];
        `AITE_NCH: d.nch = (q.wdata[7:0] == '0) ? 8'(1) : q.wdata[7:0];
        `AITE_STAT, `AITE_CNT: d.bresp = 2'b00;
        default: d.bresp = 2'b10;
      endcase
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    // axi4-lite read
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `AITE_CTRL: rd_val = q.ctrl;
      `AITE_TRIG: rd_val = q.trig;
      `AITE_SCLK: rd_val = q.sclk;
      `AITE_CCLK: rd_val = q.cclk;
      `AITE_PRE: rd_val = 32'(q.pre);
      `AITE_POST: rd_val = 32'(q.post);
      `AITE_SDIV: rd_val = 32'(q.sdiv);
      `AITE_CDIV: rd_val = 32'(q.cdiv);
      `AITE_SDLY: rd_val = {16'h0000, q.sdly};
      `AITE_CDLY: rd_val = {16'h0000, q.cdly};
      `AITE_NCH: rd_val = {24'h000000, q.nch};
      `AITE_STAT: rd_val = {24'h000000, q.chan[3:0], q.done, q.st};
      `AITE_CNT: rd_val = 32'(q.samples);
      default: begin
        rd_val = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = rd_val;
      d.rresp = rd_ok ? 2'b00 : 2'b10;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.sdly <= `AITE_SDLY_RST;
      q.cdly <= `AITE_CDLY_RST;
      q.nch <= `AITE_NCH_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = !q.aw_got;
  assign s_axi_wready = !q.w_got;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign adc_convert_strobe = q.conv;
  assign adc_channel_index = q.chan;
  assign acq_active = run;

  logic samp_out;
  assign samp_out = q.ctrl[`AITE_C_OUTLVL] ? q.in_sample : q.samp_pulse;
  generate
    for (gi = 0; gi < NLINES; gi++) begin : g_out
      assign programmable_io_line_out[gi] =
        (q.trig[`AITE_T_OUTSEL] == 4'(gi)) ? samp_out : q.start_pulse;
      assign programmable_io_line_oe[gi] = (q.trig[`AITE_T_OUTSEL] == 4'(gi)) ||
        (q.trig[`AITE_T_STSW] && q.trig[`AITE_T_STSEL] == 4'(gi));
    end
  endgenerate

  // assertions
  // no accept while idle
  a_idle_no_sample: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !run |=> !$rose(q.in_sample)) else $error("sample accepted while idle");
  a_hold_blocks: assert property (@(posedge sys_clk) disable iff (!arst_n)
    hold_gate |=> !q.samp_pulse) else $error("sample accepted while held");
  a_conv_in_sample: assert property (@(posedge sys_clk) disable iff (!arst_n)
    conv_raw && !q.in_sample |=> !q.conv) else $error("stray convert accepted");
  a_ref_early: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.st == aite_pkg::AITE_PRE && !samp_acc |=> q.st != aite_pkg::AITE_POST)
    else $error("reference accepted early");
  a_post_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.st == aite_pkg::AITE_ARMREF && ref_ev && !q.ctrl[`AITE_C_STOP] |=> q.samples == $past(q.post))
    else $error("post count not loaded");
  a_finish: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.st == aite_pkg::AITE_POST && samp_acc && q.ctrl[`AITE_C_FINITE] && q.samples == CW'(1)
    |=> q.st == aite_pkg::AITE_DONE) else $error("capture did not end");
  a_sw_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.st == aite_pkg::AITE_WAIT && q.trig[`AITE_T_STSW] && q.ctrl[`AITE_C_SWSTART]
    |=> q.start_pulse ##1 !q.start_pulse) else $error("no start pulse");
  a_channel_count: assert property (@(posedge sys_clk) disable iff (!arst_n)
    samp_acc |=> q.conv_left == $past(q.nch)) else $error("channel list not loaded");
endmodule : aite_engine

/* File: tb/aite_line_model.sv */
`timescale 1ns/1ps
module aite_line_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // commands from the bench
  input wire logic [3:0] pulse_line,
  input wire logic pulse_go,
  input wire logic [3:0] hold_line,
  input wire logic hold_on,
  // lines toward the device
  output logic [15:0] line_out
);
  logic [2:0] width_cnt;
  logic [3:0] cur;
  // strobes wide enough to be seen
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      width_cnt <= 3'h0;
      cur <= 4'h0;
    end else if (pulse_go) begin
      width_cnt <= 3'h6;
      cur <= pulse_line;
    end else if (width_cnt != 3'h0) begin
      width_cnt <= width_cnt - 3'h1;
    end
  end
  always_comb begin
    line_out = 16'h0000;
    if (width_cnt != 3'h0) line_out[cur] = 1'b1;
    if (hold_on) line_out[hold_line] = 1'b1;
  end
endmodule : aite_line_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`include "aite_regs.svh"
module tb_top;
  logic sys_clk, arst_n;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, seed, base, mode, rd;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] lin, lout, loe;
  logic [7:0] chan;
  logic conv, active, pgo, hold_on, ctr_out;
  logic [3:0] pline;
  logic [31:0] conv_cnt, nch, post, out_hi, st_hi;
  int num_errors, n_tests, i, k;

  aite_engine u_aite_engine (.sys_clk(sys_clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .programmable_io_line_in(lin), .programmable_io_line_out(lout),
    .programmable_io_line_oe(loe), .counter_internal_out(ctr_out),
    .adc_convert_strobe(conv), .adc_channel_index(chan), .acq_active(active));

  aite_line_model u_aite_line_model (.sys_clk(sys_clk), .arst_n(arst_n), .pulse_line(pline),
    .pulse_go(pgo), .hold_line(4'h2), .hold_on(hold_on), .line_out(lin));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_cnt <= 32'h0;
      out_hi <= 32'h0;
      st_hi <= 32'h0;
    end else begin
      if (conv === 1'b1) conv_cnt <= conv_cnt + 32'h1;
      // routed sample strobe and start pulse, counted only while driven
      if (lout[5] === 1'b1 && loe[5] === 1'b1) out_hi <= out_hi + 32'h1;
      if (lout[0] === 1'b1 && loe[0] === 1'b1) st_hi <= st_hi + 32'h1;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // channel count zero acts as one
  function automatic logic [31:0] eff_nch(input logic [31:0] n);
    return (n == 32'h0) ? 32'h1 : n;
  endfunction : eff_nch

  task automatic test_done();
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_up();
    num_errors++;
    $display("mismatch at %0t: bus timeout", $time);
    test_done();
  endtask : give_up

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, ah, wh;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 100 && !(aw_ok && w_ok); n++) begin
      @(negedge sys_clk);
      ah = awready & awvalid;
      wh = wready & wvalid;
      @(posedge sys_clk);
      if (ah) begin awvalid <= 1'b0; aw_ok = 1'b1; end
      if (wh) begin wvalid <= 1'b0; w_ok = 1'b1; end
    end
    if (!(aw_ok && w_ok)) give_up();
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge sys_clk);
      if (bvalid === 1'b1) break;
    end
    if (n == 100) give_up();
    resp = bresp;
    @(posedge sys_clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [11:0] a);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge sys_clk);
      if (arready === 1'b1) break;
    end
    if (n == 100) give_up();
    // address taken at this edge, release it
    @(posedge sys_clk);
    arvalid <= 1'b0;
    for (n = 0; n < 100; n++) begin
      @(negedge sys_clk);
      if (rvalid === 1'b1) break;
    end
    if (n == 100) give_up();
    rd = rdata;
    resp = rresp;
    @(posedge sys_clk);
    rready <= 1'b0;
  endtask : rdr

  // stop and disarm, then arm and start by software
  task automatic start_acq(input logic [31:0] m);
    logic [31:0] s0;
    mode = m;
    s0 = st_hi;
    wr(`AITE_CTRL, 32'h8);
    wr(`AITE_CTRL, m);
    wr(`AITE_CTRL, m | 32'h2);
    repeat (10) @(posedge sys_clk);
    check(st_hi - s0, 32'h1);
    check({31'h0, active}, 32'h1);
  endtask : start_acq

  // software sample pulse, then count conversions it caused
  task automatic sample(input logic [31:0] exp);
    int n;
    logic [31:0] o0;
    base = conv_cnt;
    o0 = out_hi;
    wr(`AITE_CTRL, mode | 32'h4);
    for (n = 0; n < 300 && conv_cnt - base != exp; n++) @(posedge sys_clk);
    repeat (30) @(posedge sys_clk);
    check(conv_cnt - base, exp);
    if (exp != 32'h0) begin
      check({24'h0, chan}, exp);
      check({31'h0, ((out_hi - o0) > 32'h1)}, {31'h0, mode[6]});
    end else begin
      check(out_hi - o0, 32'h0);
    end
  endtask : sample

  task automatic pulse(input logic [3:0] ln);
    @(posedge sys_clk);
    pline <= ln;
    pgo <= 1'b1;
    @(posedge sys_clk);
    pgo <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask : pulse

  initial begin
    arst_n = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, pgo, hold_on, ctr_out} = '0;
    pline = 4'h0;
    seed = 32'd12837;
    num_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rdr(`AITE_SDLY);
    check(rd, 32'h2);
    rdr(`AITE_CDLY);
    check(rd, 32'h3);
    rdr(`AITE_NCH);
    check(rd, 32'h1);
    rdr(12'h100);
    check({30'h0, resp}, 32'h2);
    wr(12'h104, 32'h1234);
    check({30'h0, resp}, 32'h2);
    wr(`AITE_SDIV, 32'h1);
    wr(`AITE_CDIV, 32'h1);
    wr(`AITE_CCLK, 32'h0);
    wr(`AITE_SCLK, 32'h2);
    // software start, output line 5, hold on line 2 active high, reference on line 3
    wr(`AITE_TRIG, 32'h0523_3001);
    mode = 32'h0;
    sample(32'h0);
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      nch = {30'h0, seed[1:0]};
      post = {29'h0, seed[4:2] % 3'h4} + 32'h1;
      if (i == 0) post = 32'h1;
      wr(`AITE_NCH, nch);
      wr(`AITE_POST, post);
      start_acq(32'h21);
      check({31'h0, loe[5]}, 32'h1);
      for (k = 0; k < post; k++) sample(eff_nch(nch));
      check({31'h0, active}, 32'h0);
      sample(32'h0);
    end
    wr(`AITE_NCH, 32'h2);
    wr(`AITE_POST, 32'h2);
    start_acq(32'h21);
    hold_on <= 1'b1;
    repeat (10) @(posedge sys_clk);
    sample(32'h0);
    hold_on <= 1'b0;
    repeat (10) @(posedge sys_clk);
    sample(32'h2);
    sample(32'h2);
    check({31'h0, active}, 32'h0);
    wr(`AITE_PRE, 32'h2);
    // pre-trigger with level behaviour on the routed sample output
    start_acq(32'h71);
    pulse(4'h3);
    sample(32'h2);
    sample(32'h2);
    check({31'h0, active}, 32'h1);
    sample(32'h2);
    pulse(4'h3);
    sample(32'h2);
    check({31'h0, active}, 32'h1);
    sample(32'h2);
    check({31'h0, active}, 32'h0);
    sample(32'h0);
    // divided timebase source, finite then continuous with software stop
    wr(`AITE_NCH, 32'h1);
    wr(`AITE_POST, 32'h3);
    wr(`AITE_SCLK, 32'h1);
    base = conv_cnt;
    start_acq(32'h21);
    repeat (60) @(posedge sys_clk);
    check(conv_cnt - base, 32'h3);
    check({31'h0, active}, 32'h0);
    start_acq(32'h01);
    wr(`AITE_CTRL, 32'h9);
    repeat (5) @(posedge sys_clk);
    base = conv_cnt;
    repeat (40) @(posedge sys_clk);
    check(conv_cnt - base, 32'h0);
    check({31'h0, active}, 32'h0);
    // counter output source, one rising edge held for several cycles
    wr(`AITE_SCLK, 32'h0);
    start_acq(32'h21);
    base = conv_cnt;
    ctr_out <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ctr_out <= 1'b0;
    repeat (30) @(posedge sys_clk);
    check(conv_cnt - base, 32'h1);
    // input line 4 as source, falling edge only
    wr(`AITE_SCLK, 32'h0000_0407);
    start_acq(32'h21);
    base = conv_cnt;
    pulse(4'h4);
    repeat (30) @(posedge sys_clk);
    check(conv_cnt - base, 32'h1);
    check({31'h0, active}, 32'h1);
    test_done();
  end
endmodule : tb_top
